// ==== core/frame_tracker_pkg.sv ====
// constants and types shared by the frame delimiter and shift tracker
package frame_tracker_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [6:0] IDLE_MIN_MS = 7'h01;
    localparam logic [6:0] IDLE_MAX_MS = 7'h64;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_IDLE = 8'h08;
    localparam logic [7:0] OFS_TERM = 8'h0c;
    localparam logic [7:0] OFS_SYNC = 8'h10;
    localparam logic [7:0] OFS_RELEASE = 8'h14;
    localparam logic [7:0] OFS_FLAG = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    // bit 7 of the address selects the defined-code mask words
    localparam int MASK_SEL_BIT = 7;

    // field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int MODE_PROTO_LSB = 0;
    localparam int MODE_CODE_LSB = 4;
    localparam int STAT_FRAME_BIT = 0;
    localparam int STAT_SHIFT_BIT = 1;
    localparam int STAT_COUNT_LSB = 16;

    // reset values
    localparam logic [6:0] RST_IDLE_MS = 7'h0a;
    localparam logic [7:0] RST_TERM = 8'h0d;
    localparam logic [7:0] RST_SYNC = 8'h32;
    localparam logic [7:0] RST_RELEASE = 8'h37;
    localparam logic [7:0] RST_FLAG = 8'h7e;

    // shift codes per code set
    localparam logic [7:0] JIS7_SI = 8'h0f;
    localparam logic [7:0] JIS7_SO = 8'h0e;
    localparam logic [7:0] BAUDOT_SI = 8'h1f;
    localparam logic [7:0] BAUDOT_SO = 8'h1b;
    localparam logic [7:0] EBCD_SI = 8'h1f;
    localparam logic [7:0] EBCD_SO = 8'h1c;

    typedef enum logic [1:0] {
        PROTO_ASYNC = 2'b00,
        PROTO_SYNC = 2'b01,
        PROTO_HDLC = 2'b10,
        PROTO_PPP = 2'b11
    } proto_t;

    typedef enum logic [3:0] {
        CODE_ASCII = 4'b0000,
        CODE_EBCDIC = 4'b0001,
        CODE_JIS7 = 4'b0010,
        CODE_JIS8 = 4'b0011,
        CODE_EBCDIK = 4'b0100,
        CODE_BAUDOT = 4'b0101,
        CODE_EBCD = 4'b0110,
        CODE_TRANSCODE = 4'b0111,
        CODE_IPARS = 4'b1000
    } code_set_t;

    typedef enum logic [0:0] {
        FR_HUNT = 1'b0,
        FR_OPEN = 1'b1
    } frame_state_t;
endpackage

// ==== core/code_mask_if.sv ====
// carrier between the tracker and its defined-code mask memory
`timescale 1ns/1ps
`default_nettype none
interface code_mask_if;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
    logic rd_en;
    logic [4:0] rd_addr;
    logic [15:0] rd_data;
    modport owner (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                   input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
                 output rd_data);
endinterface
`default_nettype wire

// ==== core/code_mask_mem.sv ====
// defined-code mask memory: one bit per code, per shift table
`timescale 1ns/1ps
`default_nettype none
module code_mask_mem (
    input wire logic clock_i,
    input wire logic rst_i,
    code_mask_if.mem bus
);
    // word = {shift table, high nibble}, bit = low nibble
    logic [15:0] mem [0:31];
    logic [15:0] rd_data;

    always_ff @(posedge clock_i) begin
        if (bus.wr_en) begin
            mem[bus.wr_addr] <= bus.wr_data;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data <= 16'h0000;
        end else if (bus.rd_en) begin
            rd_data <= mem[bus.rd_addr];
        end
    end

    assign bus.rd_data = rd_data;
endmodule
`default_nettype wire

// ==== core/frame_delimiter_shift_tracker.sv ====
// frame delimiting and shift-state tracking for a captured char stream
//
// Overview of operation
// - async: close open frame after programmed idle gap of 1 to 100 ms
// - async: terminator character closes the frame, whichever end comes first
// - sync: frame opens at sync character, runs until release character
// - hdlc: data between one flag and the next flag is one frame
// - ppp: flag to flag is a frame; escape codes pass undecoded
// - codes with no table entry are flagged for hexadecimal display
// - jis7, ebcd, baudot: SI and SO codes switch between the two tables
// - run command resets shift state to shift-in before any character
// - shift-in table stays until SO; shift-out stays until SI
// - jis7: shift-in selects roman table, shift-out selects kana
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module frame_delimiter_shift_tracker
    import frame_tracker_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic char_valid_i,
    input wire logic [7:0] char_i,
    output logic frame_start_o,
    output logic frame_end_o,
    output logic in_frame_o,
    output logic shift_out_o,
    output logic out_valid_o,
    output logic [7:0] out_code_o,
    output logic out_hex_o,
    output logic out_shift_o
);
    function automatic logic [7:0] shift_code(input code_set_t cs,
                                              input logic want_so);
        logic [7:0] code;
        code = 8'h00;
        if (cs == CODE_JIS7) begin
            code = want_so ? JIS7_SO : JIS7_SI;
        end else if (cs == CODE_BAUDOT) begin
            code = want_so ? BAUDOT_SO : BAUDOT_SI;
        end else if (cs == CODE_EBCD) begin
            code = want_so ? EBCD_SO : EBCD_SI;
        end
        return code;
    endfunction

    code_mask_if mask_bus ();

    code_mask_mem u_mask (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .bus(mask_bus)
    );

    logic running;
    proto_t proto;
    code_set_t code_set;
    logic [6:0] idle_gap;
    logic [7:0] term_char;
    logic [7:0] sync_char;
    logic [7:0] release_char;
    logic [7:0] flag_char;
    frame_state_t state;
    logic shift_out;
    logic data_seen;
    logic [15:0] frame_count;
    logic [31:0] ms_cnt;
    logic [6:0] idle_ms;
    logic s1_valid;
    logic [7:0] s1_code;
    logic [3:0] s1_nib;
    logic s1_shift;

    // register decode
    wire wr_mask = wr_i && addr_i[MASK_SEL_BIT];
    wire wr_ctrl = wr_i && (addr_i == OFS_CTRL);
    wire wr_mode = wr_i && (addr_i == OFS_MODE);
    wire wr_idle = wr_i && (addr_i == OFS_IDLE);
    wire run_cmd = wr_ctrl && wdata_i[CTRL_RUN_BIT];
    wire [6:0] gap_wr = wdata_i[6:0];
    wire [6:0] gap_clamped = (wdata_i[31:7] != 25'h0000000) ? IDLE_MAX_MS :
        (gap_wr < IDLE_MIN_MS) ? IDLE_MIN_MS :
        (gap_wr > IDLE_MAX_MS) ? IDLE_MAX_MS : gap_wr;

    wire [31:0] status_word = {frame_count, 14'h0000, shift_out,
                               (state == FR_OPEN)};
    wire [31:0] rd_word =
        (addr_i == OFS_CTRL) ? {31'h00000000, running} :
        (addr_i == OFS_MODE) ? {24'h000000, code_set, 2'h0, proto} :
        (addr_i == OFS_IDLE) ? {25'h0000000, idle_gap} :
        (addr_i == OFS_TERM) ? {24'h000000, term_char} :
        (addr_i == OFS_SYNC) ? {24'h000000, sync_char} :
        (addr_i == OFS_RELEASE) ? {24'h000000, release_char} :
        (addr_i == OFS_FLAG) ? {24'h000000, flag_char} :
        (addr_i == OFS_STATUS) ? status_word : 32'h00000000;

    // character classification
    // any control write wins over a character arriving in the same cycle
    wire take = char_valid_i && running && !wr_ctrl;
    wire is_term = char_i == term_char;
    wire is_sync = char_i == sync_char;
    wire is_release = char_i == release_char;
    // escape codes get no special treatment: only the flag delimits
    wire is_flag = char_i == flag_char;
    wire shift_set = (code_set == CODE_JIS7) || (code_set == CODE_BAUDOT) ||
                     (code_set == CODE_EBCD);
    wire is_si = shift_set && (char_i == shift_code(code_set, 1'b0));
    wire is_so = shift_set && (char_i == shift_code(code_set, 1'b1));
    wire is_open = state == FR_OPEN;
    wire flag_mode = (proto == PROTO_HDLC) || (proto == PROTO_PPP);

    // frame start and end decisions
    wire idle_end = (proto == PROTO_ASYNC) && is_open && !take &&
                    (idle_ms >= idle_gap);
    wire async_start = (proto == PROTO_ASYNC) && take && !is_open;
    wire async_end = (proto == PROTO_ASYNC) && take && is_term;
    wire sync_start = (proto == PROTO_SYNC) && take && !is_open &&
                      is_sync;
    wire sync_end = (proto == PROTO_SYNC) && take && is_open &&
                    is_release;
    wire flag_start = flag_mode && take && is_open && !is_flag &&
                      !data_seen;
    wire flag_end = flag_mode && take && is_open && is_flag &&
                    data_seen;
    wire start_evt = async_start || sync_start || flag_start;
    wire end_evt = idle_end || async_end || sync_end || flag_end;

    wire next_open_async = async_end ? 1'b0 : (async_start || is_open);
    wire next_open_sync = sync_end ? 1'b0 : (sync_start || is_open);
    // a flag both closes one frame and opens the next
    wire next_open_flag = (take && is_flag) || is_open;
    wire next_open = (proto == PROTO_ASYNC) ? (next_open_async && !idle_end) :
                     (proto == PROTO_SYNC) ? next_open_sync : next_open_flag;
    wire next_data_seen = (take && is_flag) ? 1'b0 :
                          (take && is_open) ? 1'b1 : data_seen;
    wire next_shift = is_si ? 1'b0 : is_so ? 1'b1 : shift_out;
    wire ms_wrap = ms_cnt == 32'(MS_CYCLES_P - 1);

    // configuration registers
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            proto <= PROTO_ASYNC;
            code_set <= CODE_ASCII;
            idle_gap <= RST_IDLE_MS;
        end else begin
            if (wr_mode) begin
                proto <= proto_t'(wdata_i[MODE_PROTO_LSB +: 2]);
                code_set <= code_set_t'(wdata_i[MODE_CODE_LSB +: 4]);
            end
            if (wr_idle) begin
                idle_gap <= gap_clamped;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            term_char <= RST_TERM;
            sync_char <= RST_SYNC;
            release_char <= RST_RELEASE;
            flag_char <= RST_FLAG;
        end else if (wr_i) begin
            if (addr_i == OFS_TERM) begin
                term_char <= wdata_i[7:0];
            end else if (addr_i == OFS_SYNC) begin
                sync_char <= wdata_i[7:0];
            end else if (addr_i == OFS_RELEASE) begin
                release_char <= wdata_i[7:0];
            end else if (addr_i == OFS_FLAG) begin
                flag_char <= wdata_i[7:0];
            end
        end
    end

    // frame and shift state; run restarts everything
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            running <= 1'b0;
            state <= FR_HUNT;
            shift_out <= 1'b0;
            data_seen <= 1'b0;
            frame_count <= 16'h0000;
        end else if (wr_ctrl) begin
            running <= wdata_i[CTRL_RUN_BIT];
            state <= FR_HUNT;
            shift_out <= 1'b0;
            data_seen <= 1'b0;
            if (run_cmd) begin
                frame_count <= 16'h0000;
            end
        end else if (running) begin
            state <= next_open ? FR_OPEN : FR_HUNT;
            data_seen <= next_data_seen;
            if (take) begin
                shift_out <= next_shift;
            end
            if (end_evt) begin
                frame_count <= frame_count + 16'h0001;
            end
        end
    end

    // idle gap timer restarts at the end of each received character
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ms_cnt <= 32'h00000000;
            idle_ms <= 7'h00;
        end else if (take || !is_open || wr_ctrl) begin
            ms_cnt <= 32'h00000000;
            idle_ms <= 7'h00;
        end else if (idle_ms != IDLE_MAX_MS) begin
            ms_cnt <= ms_wrap ? 32'h00000000 : ms_cnt + 32'h00000001;
            if (ms_wrap) begin
                idle_ms <= idle_ms + 7'h01;
            end
        end
    end

    // mask lookup: table half follows the shift state in force
    assign mask_bus.wr_en = wr_mask;
    assign mask_bus.wr_addr = addr_i[6:2];
    assign mask_bus.wr_data = wdata_i[15:0];
    assign mask_bus.rd_en = take;
    assign mask_bus.rd_addr = {shift_out, char_i[7:4]};

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s1_valid <= 1'b0;
            s1_code <= 8'h00;
            s1_nib <= 4'h0;
            s1_shift <= 1'b0;
        end else begin
            s1_valid <= take;
            if (take) begin
                s1_code <= char_i;
                s1_nib <= char_i[3:0];
                s1_shift <= shift_out;
            end
        end
    end

    // outputs
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            out_code_o <= 8'h00;
            out_hex_o <= 1'b0;
            out_shift_o <= 1'b0;
        end else begin
            out_valid_o <= s1_valid;
            out_code_o <= s1_code;
            out_hex_o <= s1_valid && !mask_bus.rd_data[s1_nib];
            out_shift_o <= s1_shift;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            frame_start_o <= 1'b0;
            frame_end_o <= 1'b0;
            in_frame_o <= 1'b0;
            shift_out_o <= 1'b0;
            rdata_o <= 32'h00000000;
        end else begin
            frame_start_o <= start_evt && running && !wr_ctrl;
            frame_end_o <= end_evt && running && !wr_ctrl;
            in_frame_o <= (state == FR_OPEN);
            shift_out_o <= shift_out;
            // read data stand only in the cycle after the strobe
            rdata_o <= rd_i ? rd_word : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ==== tb/frame_tracker_properties.sv ====
// port assertions for the frame tracker
`timescale 1ns/1ps
`default_nettype none
module frame_tracker_properties
    import frame_tracker_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic char_valid_i,
    input wire logic frame_start_o,
    input wire logic frame_end_o,
    input wire logic in_frame_o,
    input wire logic shift_out_o,
    input wire logic out_valid_o
);
    int quiet;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_run_cmd;
        wr_i && addr_i == OFS_CTRL;
    endsequence
    sequence s_shift_cause;
        $past(char_valid_i) || $past(char_valid_i, 2) || $past(wr_i) ||
            $past(wr_i, 2);
    endsequence
    // saturates so a long quiet line cannot wrap back below the gap
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            quiet <= 0;
        end else begin
            quiet <= char_valid_i ? 0 :
                (quiet < MS_CYCLES_P ? quiet + 1 : quiet);
        end
    end
    chk_start_by_char: assert property (
        frame_start_o |-> $past(char_valid_i))
        else $error("frame start without a character");
    chk_out_latency: assert property (
        out_valid_o |-> $past(char_valid_i, 2))
        else $error("output char without input two cycles before");
    // flag modes open on the flag itself, before any start pulse
    chk_open_follows: assert property (
        $rose(in_frame_o) |-> $past(char_valid_i, 2))
        else $error("frame open without a character");
    chk_start_opens: assert property (
        frame_start_o && !frame_end_o |=> in_frame_o)
        else $error("start pulse without open frame");
    chk_close_follows: assert property (
        $fell(in_frame_o) |-> $past(frame_end_o) || $past(wr_i) ||
            $past(wr_i, 2))
        else $error("frame closed without end pulse");
    chk_run_shift_in: assert property (
        s_run_cmd |=> ##[0:1] !shift_out_o)
        else $error("run command left shift-out selected");
    chk_shift_hold: assert property (
        $changed(shift_out_o) |-> s_shift_cause)
        else $error("shift state moved with no char or command");
    chk_idle_gap: assert property (
        frame_end_o |-> $past(char_valid_i) || quiet >= MS_CYCLES_P - 1)
        else $error("frame end before idle gap");
    chk_end_open: assert property (
        frame_end_o && !$past(char_valid_i) |-> in_frame_o)
        else $error("idle end while no frame open");
endmodule
bind frame_delimiter_shift_tracker frame_tracker_properties #(
    .MS_CYCLES_P(MS_CYCLES_P)
) chk_i (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wr_i(wr_i),
    .char_valid_i(char_valid_i),
    .frame_start_o(frame_start_o),
    .frame_end_o(frame_end_o),
    .in_frame_o(in_frame_o),
    .shift_out_o(shift_out_o),
    .out_valid_o(out_valid_o)
);
`default_nettype wire

// ==== tb/serial_line_model.sv ====
// monitored line: emits queued characters, one per cycle at most
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
    input wire logic clock_i,
    input wire logic rst_i,
    output logic char_valid_o,
    output logic [7:0] char_o
);
    logic [7:0] pend[$];
    task automatic push(input logic [7:0] c);
        pend.push_back(c);
    endtask
    // idle code lines toggle so no stale char looks valid
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            char_valid_o <= 1'b0;
            char_o <= 8'h00;
        end else if (pend.size() > 0) begin
            char_valid_o <= 1'b1;
            char_o <= pend.pop_front();
        end else begin
            char_valid_o <= 1'b0;
            char_o <= ~char_o;
        end
    end
endmodule
`default_nettype wire

// ==== tb/frame_delimiter_shift_tracker_tb_top.sv ====
// self-checking bench for the frame delimiter and shift tracker
`timescale 1ns/1ps
`default_nettype none
module frame_delimiter_shift_tracker_tb_top;
    import frame_tracker_pkg::*;
    localparam int MSC = 4;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic char_valid_i;
    logic [7:0] char_i, out_code_o;
    logic frame_start_o, frame_end_o, in_frame_o, shift_out_o;
    logic out_valid_o, out_hex_o, out_shift_o;
    int error_cnt = 0;
    int checks = 0;
    int starts = 0;
    int ends = 0;
    int s0 = 0;
    int e0 = 0;
    int cyc = 0;
    logic [3:0] cset = 4'h0;
    logic shst = 1'b0;
    logic [9:0] expq[$];
    frame_delimiter_shift_tracker #(.MS_CYCLES_P(MSC)) dut (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .char_valid_i(char_valid_i),
        .char_i(char_i),
        .frame_start_o(frame_start_o),
        .frame_end_o(frame_end_o),
        .in_frame_o(in_frame_o),
        .shift_out_o(shift_out_o),
        .out_valid_o(out_valid_o),
        .out_code_o(out_code_o),
        .out_hex_o(out_hex_o),
        .out_shift_o(out_shift_o)
    );
    serial_line_model line (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .char_valid_o(char_valid_i),
        .char_o(char_i)
    );
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    task automatic fail(input string m);
        error_cnt++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        checks++;
        if (g !== e) fail(m);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    function automatic logic nshift(input logic [3:0] cs, input logic s,
                                    input logic [7:0] c);
        logic [15:0] p;
        case (cs)
            CODE_JIS7: p = {JIS7_SI, JIS7_SO};
            CODE_BAUDOT: p = {BAUDOT_SI, BAUDOT_SO};
            CODE_EBCD: p = {EBCD_SI, EBCD_SO};
            default: return s;
        endcase
        return (c == p[15:8]) ? 1'b0 : (c == p[7:0]) ? 1'b1 : s;
    endfunction
    task automatic setup(input logic [1:0] p, input logic [3:0] cs);
        wr(OFS_MODE, {24'h0, cs, 2'b00, p});
        wr(OFS_CTRL, 32'h1);
        cset = cs;
        shst = 1'b0;
    endtask
    task automatic put(input logic [7:0] c);
        expq.push_back({c[7:4] == 4'h8, shst, c});
        shst = nshift(cset, shst, c);
        line.push(c);
    endtask
    task automatic drain();
        while (line.pend.size() > 0) @(posedge clock_i);
        repeat (3) @(posedge clock_i);
    endtask
    task automatic fr(input int ds, input int de);
        chk(32'(starts - s0), 32'(ds), "frame starts");
        chk(32'(ends - e0), 32'(de), "frame ends");
        s0 = starts;
        e0 = ends;
    endtask
    // sampled mid-cycle so registered outputs have settled
    always @(negedge clock_i) begin
        cyc++;
        starts += int'(frame_start_o === 1'b1);
        ends += int'(frame_end_o === 1'b1);
        if (out_valid_o === 1'b1) begin
            if (expq.size() == 0) fail("unexpected char");
            else chk(32'({out_hex_o, out_shift_o, out_code_o}),
                     32'(expq.pop_front()), "char out");
        end
        if (cyc == 20000) begin
            fail("timeout");
            summarize();
        end
    end
    initial begin
        logic [31:0] d;
        logic [7:0] so [4] = '{JIS7_SO, BAUDOT_SO, EBCD_SO, JIS7_SO};
        logic [7:0] si [4] = '{JIS7_SI, BAUDOT_SI, EBCD_SI, JIS7_SI};
        logic [3:0] cs [4] = '{CODE_JIS7, CODE_BAUDOT, CODE_EBCD, CODE_ASCII};
        void'($urandom(63));
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(OFS_IDLE, d);
        chk(d, {25'h0, RST_IDLE_MS}, "idle reset");
        rd(8'h40, d);
        chk(d, 32'h0, "unmapped read");
        wr(OFS_IDLE, 32'h0);
        rd(OFS_IDLE, d);
        chk(d, {25'h0, IDLE_MIN_MS}, "idle low clamp");
        wr(OFS_IDLE, 32'h7f);
        rd(OFS_IDLE, d);
        chk(d, {25'h0, IDLE_MAX_MS}, "idle high clamp");
        for (int n = 0; n < 32; n++) begin
            wr(8'h80 | 8'(n << 2), (n[3:0] == 4'h8) ? 32'h0 : 32'hffff);
        end
        $display("test registers done");
        wr(OFS_IDLE, 32'h2);
        setup(PROTO_ASYNC, CODE_ASCII);
        repeat (6) put(8'($urandom_range(8'h80, 8'h9f)));
        put(RST_TERM);
        drain();
        fr(1, 1);
        put(8'h42);
        drain();
        fr(1, 0);
        repeat (12) @(posedge clock_i);
        fr(0, 1);
        chk(32'(in_frame_o), 32'h0, "frame left open");
        $display("test async done");
        setup(PROTO_SYNC, CODE_ASCII);
        repeat (4) put(8'($urandom_range(8'h40, 8'h7d)));
        drain();
        fr(0, 0);
        put(RST_SYNC);
        repeat (3) put(8'($urandom_range(8'h40, 8'h7d)));
        put(RST_RELEASE);
        drain();
        fr(1, 1);
        $display("test sync done");
        for (int p = 2; p < 4; p++) begin
            setup(2'(p), CODE_ASCII);
            put(RST_FLAG);
            put(RST_FLAG);
            drain();
            fr(0, 0);
            repeat (3) put(8'($urandom_range(8'h40, 8'h7d)));
            if (p == 3) put(8'h7d);
            put(8'h5e);
            put(RST_FLAG);
            drain();
            fr(1, 1);
        end
        $display("test flag framing done");
        for (int k = 0; k < 4; k++) begin
            setup(PROTO_ASYNC, cs[k]);
            put(8'($urandom_range(0, 8'h1a)));
            put(so[k]);
            put(8'($urandom_range(0, 8'h1a)));
            put(so[k]);
            drain();
            rd(OFS_STATUS, d);
            chk(32'(d[1]), 32'(k < 3), "shift-out state");
            put(si[k]);
            put(8'($urandom_range(0, 8'h1a)));
            put(so[k]);
            drain();
            wr(OFS_CTRL, 32'h1);
            shst = 1'b0;
            // the shift level output lags the internal state by one cycle
            @(posedge clock_i);
            #1 chk(32'(shift_out_o), 32'h0, "run shift state");
            put(8'($urandom_range(0, 8'h1a)));
            drain();
        end
        $display("test shift tracking done");
        chk(32'(expq.size()), 32'h0, "chars missing");
        summarize();
    end
endmodule
`default_nettype wire
